// ===== design/psl_top.sv
// serializer and deserializer control and data path of the pixel serdes link
`timescale 1ns/1ns
module psl_top
   import psl_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic tx_pixel_clock,
   input wire logic [`PSL_WORD_BITS-1:0] tx_pixel_data,
   input wire logic tx_edge_select,
   input wire logic tx_serial_out_enable,
   input wire logic tx_powerdown_n,
   input wire logic tx_scramble_bypass,
   output logic [`PSL_SYM_BITS-1:0] tx_serial_out,
   output logic tx_serial_oe,
   output logic tx_overrun,
   input wire logic [`PSL_SYM_BITS-1:0] rx_serial_in,
   input wire logic rx_edge_select,
   input wire logic rx_parallel_out_enable,
   input wire logic rx_powerdown_n,
   input wire logic rx_scramble_bypass,
   input wire logic staggered_output_select,
   output logic [`PSL_WORD_BITS-1:0] rx_parallel_out,
   output logic rx_pixel_clock_out,
   output logic rx_out_oe,
   output logic rx_lock,
   output logic rx_lock_oe
);

   psl_state_t s_r;
   psl_state_t s_nxt;
   psl_pins_t pins;

   logic fifo_reset;
   logic cap_valid;
   logic cap_ready;
   logic [`PSL_WORD_BITS-1:0] cap_data;
   logic pop_valid;
   logic pop_ready;
   logic [`PSL_WORD_BITS-1:0] pop_data;

   // self-synchronising mixer: the far end needs only the last received word,
   // so no training or seed exchange is needed to come into step
   function automatic logic [`PSL_WORD_BITS-1:0] psl_mix(input logic [`PSL_WORD_BITS-1:0] p);
      psl_mix = {p[22:0], p[23] ^ p[22] ^ p[21] ^ p[16]};
   endfunction

   ////////////////////////////////////////////////////////////////
   // pin inputs
   always_comb begin
      pins.pclk = tx_pixel_clock;
      pins.pdata = tx_pixel_data;
      pins.tx_edge = tx_edge_select;
      pins.tx_en = tx_serial_out_enable;
      pins.tx_pd_n = tx_powerdown_n;
      pins.tx_byp = tx_scramble_bypass;
      pins.ser_in = rx_serial_in;
      pins.rx_edge = rx_edge_select;
      pins.rx_en = rx_parallel_out_enable;
      pins.rx_pd_n = rx_powerdown_n;
      pins.rx_byp = rx_scramble_bypass;
      pins.stag = staggered_output_select;
   end

   ////////////////////////////////////////////////////////////////
   // capture buffer between the pixel clock side and the serializer
   assign fifo_reset = reset || !s_r.pin2.tx_pd_n;
   assign pop_ready = s_r.tx_active && (s_r.tx_sym == `PSL_LAST_SYM);

   psl_fifo #(
      .WIDTH(`PSL_WORD_BITS),
      .DEPTH(`PSL_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(fifo_reset),
      .in_valid(cap_valid),
      .in_ready(cap_ready),
      .in_data(cap_data),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_data)
   );

   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic p2_rise;
      logic p2_fall;
      logic tx_load;
      logic [`PSL_WORD_BITS-1:0] tx_word;
      logic [`PSL_WORD_BITS-1:0] tx_scr;
      logic [`PSL_FRAME_BITS-1:0] rx_frame;
      logic rx_ok;
      logic [`PSL_WORD_BITS-1:0] rx_data;
      logic [3:0] g1_at;
      logic [3:0] g23_at;

      p2_rise = 1'b0;
      p2_fall = 1'b0;
      tx_load = 1'b0;
      tx_word = '0;
      tx_scr = '0;
      rx_frame = '0;
      rx_ok = 1'b0;
      rx_data = '0;
      g1_at = 4'h0;
      g23_at = 4'h0;

      s_nxt = s_r;
      s_nxt.pin1 = pins;
      s_nxt.pin2 = s_r.pin1;
      s_nxt.pclk_d = s_r.pin2.pclk;

      // ---------------- serializer ----------------
      p2_rise = s_r.pin2.pclk && !s_r.pclk_d;
      p2_fall = !s_r.pin2.pclk && s_r.pclk_d;
      // R08: capture edge select
      cap_valid = s_r.pin2.tx_pd_n && (s_r.pin2.tx_edge ? p2_rise : p2_fall);
      // R15: no line length counted
      // R03: one 24-bit word per pixel clock
      cap_data = s_r.pin2.pdata;

      if (!s_r.pin2.tx_pd_n) begin
         s_nxt.tx_active = 1'b0;
         s_nxt.tx_overrun = 1'b0;
         s_nxt.tx_sym = 4'h0;
         s_nxt.tx_shift = '0;
         s_nxt.tx_prev = '0;
         s_nxt.tx_out = '0;
      end else begin
         // the pixel clock must have ticked before the line is driven
         if (cap_valid) begin
            s_nxt.tx_active = 1'b1;
         end
         // a word lost to a full buffer is flagged, never silent
         if (cap_valid && !cap_ready) begin
            s_nxt.tx_overrun = 1'b1;
         end
         if (s_r.tx_active) begin
            tx_load = (s_r.tx_sym == `PSL_LAST_SYM);
            s_nxt.tx_sym = tx_load ? 4'h0 : s_r.tx_sym + 4'h1;
            s_nxt.tx_out = s_r.tx_shift[`PSL_FRAME_BITS-1 -: `PSL_SYM_BITS];
            if (tx_load) begin
               tx_word = pop_valid ? pop_data : '0;
               // R01: bypass sends the word plain
               // R02: otherwise scramble against the last sent word
               tx_scr = s_r.pin2.tx_byp ? tx_word : (tx_word ^ psl_mix(s_r.tx_prev));
               s_nxt.tx_prev = tx_scr;
               // R04: start one and stop zeros embed the clock in each frame
               s_nxt.tx_shift = {1'b1, pop_valid, tx_scr, 2'b00};
            end else begin
               s_nxt.tx_shift = {s_r.tx_shift[`PSL_FRAME_BITS-`PSL_SYM_BITS-1:0], {`PSL_SYM_BITS{1'b0}}};
            end
         end
      end

      // ---------------- deserializer ----------------
      rx_frame = {s_r.rx_shift[`PSL_FRAME_BITS-`PSL_SYM_BITS-1:0], s_r.pin2.ser_in};
      g1_at = s_r.pin2.stag ? `PSL_STAG_G1 : 4'h0;
      g23_at = s_r.pin2.stag ? `PSL_STAG_G23 : 4'h0;

      if (!s_r.pin2.rx_pd_n) begin
         s_nxt.rx_shift = '0;
         s_nxt.rx_phase = 4'h0;
         s_nxt.rx_good = 3'h0;
         s_nxt.rx_lock = 1'b0;
         s_nxt.rx_prev = '0;
         s_nxt.rx_age = `PSL_AGE_MAX;
      end else begin
         s_nxt.rx_shift = rx_frame;
         if (s_r.rx_age != `PSL_AGE_MAX) begin
            s_nxt.rx_age = s_r.rx_age + 4'h1;
         end
         if (s_r.rx_phase != `PSL_LAST_SYM) begin
            s_nxt.rx_phase = s_r.rx_phase + 4'h1;
         end else begin
            // R04: recover framing from the embedded start and stop marks
            rx_ok = rx_frame[`PSL_FRAME_BITS-1] && (rx_frame[1:0] == 2'b00);
            if (rx_ok) begin
               s_nxt.rx_phase = 4'h0;
               if (s_r.rx_good != `PSL_LOCK_FRAMES) begin
                  s_nxt.rx_good = s_r.rx_good + 3'h1;
               end
               // R05: lock after enough good marks in a row
               // R14: any live data locks, no training pattern needed
               s_nxt.rx_lock = (s_nxt.rx_good == `PSL_LOCK_FRAMES);
               // R01: bypass takes the word plain
               // R02: otherwise descramble against the last received word
               rx_data = s_r.pin2.rx_byp ? rx_frame[25:2] : (rx_frame[25:2] ^ psl_mix(s_r.rx_prev));
               s_nxt.rx_prev = rx_frame[25:2];
               if (s_nxt.rx_lock && rx_frame[26]) begin
                  s_nxt.rx_word = rx_data;
                  s_nxt.rx_age = 4'h0;
               end
            end else begin
               // holding the phase slips the frame by one symbol; random
               // data may alias a mark, so lock needs several in a row
               s_nxt.rx_good = 3'h0;
               s_nxt.rx_lock = 1'b0;
            end
         end
      end

      // R13: banks update apart to spread output switching
      // R16: first byte two link periods late, the others one
      if (s_r.rx_age == g1_at) begin
         s_nxt.rx_out[7:0] = s_r.rx_word[7:0];
      end
      if (s_r.rx_age == g23_at) begin
         s_nxt.rx_out[23:8] = s_r.rx_word[23:8];
      end
      // R09: edge high puts the rising clock edge after all banks settle
      s_nxt.rx_clk = s_r.pin2.rx_edge ? (s_r.rx_age >= `PSL_RXCLK_RISE) : (s_r.rx_age < `PSL_RXCLK_RISE);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
         s_r.rx_age <= `PSL_AGE_MAX;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs and enables
   assign tx_serial_out = s_r.tx_out;
   assign tx_serial_oe = s_r.pin2.tx_pd_n && s_r.pin2.tx_en && s_r.tx_active;
   assign tx_overrun = s_r.tx_overrun;
   assign rx_parallel_out = s_r.rx_out;
   assign rx_pixel_clock_out = s_r.rx_clk;
   // parallel outputs float unless powered, enabled and locked
   assign rx_out_oe = s_r.pin2.rx_pd_n && s_r.pin2.rx_en && s_r.rx_lock;
   assign rx_lock = s_r.rx_lock;
   assign rx_lock_oe = s_r.pin2.rx_pd_n;
endmodule

// ===== design/psl_cfg.svh
// constants for the pixel serdes link: widths, framing, lock and stagger timing
//
// What this block does
// R01: a high scramble bypass turns off the extra pseudo-random coding on each end for the older generation.
// R02: with bypass low on both ends the serializer scrambles and the deserializer descrambles.
// R03: the serializer carries 24 parallel bits per pixel clock over one serial link.
// R04: clock is embedded in the serial frames and the deserializer recovers it without a reference clock.
// R05: the deserializer watches the embedded clock marks and drives lock high once locked.
// R06: the host maps six red, six green, six blue, the syncs, display enable and three spares onto the 24 lanes.
// R07: the host supplies a pixel clock between 5 and 43 MHz.
// R08: with tx edge select high the inputs are captured on the rising pixel clock edge.
// R09: with rx edge select high the outputs are set up to be strobed on the rising recovered clock edge.
// R10: the host holds the serial output enable high when it does not control it.
// R11: the host holds the parallel output enable high when it does not control it.
// R12: host outputs drive the active-low power-down inputs of both ends.
// R13: staggered output select delays the output banks against each other.
// R14: after live insertion the deserializer locks to arbitrary data with no training sequence.
// R15: the link carries display formats up to 1280 by 480 at eighteen-bit colour.
// R16: fixed stagger splits the outputs into three bytes, the first two link periods and the others one from the clock.
`ifndef PSL_CFG_SVH
`define PSL_CFG_SVH

`define PSL_WORD_BITS 24
`define PSL_SYM_BITS 2
`define PSL_FRAME_BITS 28
`define PSL_FRAME_SYMS 14
`define PSL_FIFO_DEPTH 32
`define PSL_LOCK_FRAMES 3'h4
`define PSL_UI_CYCLES 4'h1
`define PSL_STAG_G1 (4'h2 * `PSL_UI_CYCLES)
`define PSL_STAG_G23 (4'h1 * `PSL_UI_CYCLES)
`define PSL_RXCLK_RISE 4'h5
`define PSL_AGE_MAX 4'hf
`define PSL_LAST_SYM 4'hd

`endif

// ===== design/psl_pkg.sv
// types for the pixel serdes link
`include "psl_cfg.svh"
package psl_pkg;

   typedef struct packed {
      logic pclk;
      logic [`PSL_WORD_BITS-1:0] pdata;
      logic tx_edge;
      logic tx_en;
      logic tx_pd_n;
      logic tx_byp;
      logic [`PSL_SYM_BITS-1:0] ser_in;
      logic rx_edge;
      logic rx_en;
      logic rx_pd_n;
      logic rx_byp;
      logic stag;
   } psl_pins_t;

   typedef struct packed {
      psl_pins_t pin1;
      psl_pins_t pin2;
      logic pclk_d;
      logic tx_active;
      logic tx_overrun;
      logic [`PSL_FRAME_BITS-1:0] tx_shift;
      logic [3:0] tx_sym;
      logic [`PSL_WORD_BITS-1:0] tx_prev;
      logic [`PSL_SYM_BITS-1:0] tx_out;
      logic [`PSL_FRAME_BITS-1:0] rx_shift;
      logic [3:0] rx_phase;
      logic [2:0] rx_good;
      logic rx_lock;
      logic [`PSL_WORD_BITS-1:0] rx_prev;
      logic [`PSL_WORD_BITS-1:0] rx_word;
      logic [`PSL_WORD_BITS-1:0] rx_out;
      logic [3:0] rx_age;
      logic rx_clk;
   } psl_state_t;

endpackage

// ===== design/psl_fifo.sv
// parameterised fifo with registered read data
`timescale 1ns/1ns
module psl_fifo
   import psl_pkg::*;
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } psl_fifo_st_t;

   psl_fifo_st_t s_r;
   psl_fifo_st_t s_nxt;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////
   // full is honest: the output stage is not counted as free room
   assign in_ready = (s_r.cnt < (AW+1)'(DEPTH));
   assign out_valid = s_r.ov;
   assign out_data = s_r.od;

   always_comb begin
      s_nxt = s_r;
      push = in_valid && in_ready;
      pop = (s_r.cnt != '0) && (!s_r.ov || out_ready);
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.od = s_r.mem[s_r.rp];
         s_nxt.rp = s_r.rp + 1'b1;
         s_nxt.ov = 1'b1;
      end else if (out_ready) begin
         s_nxt.ov = 1'b0;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ===== test/psl_top_properties.sv
// concurrent port checks for the pixel serdes link
`timescale 1ns/1ns
`include "psl_cfg.svh"
module psl_top_properties (
   input wire logic clk,
   input wire logic reset,
   input wire logic tx_powerdown_n,
   input wire logic tx_serial_out_enable,
   input wire logic tx_serial_oe,
   input wire logic tx_overrun,
   input wire logic rx_edge_select,
   input wire logic rx_parallel_out_enable,
   input wire logic rx_powerdown_n,
   input wire logic staggered_output_select,
   input wire logic [`PSL_WORD_BITS-1:0] rx_parallel_out,
   input wire logic rx_pixel_clock_out,
   input wire logic rx_out_oe,
   input wire logic rx_lock,
   input wire logic rx_lock_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////
   // guarded by lock so a reset clear is not taken for a new word
   sequence hi_moves;
      rx_lock && $changed(rx_parallel_out[23:8]);
   endsequence
   sequence lo_moves;
      rx_lock && $changed(rx_parallel_out[7:0]);
   endsequence
   ////////////////////////////////
   // line follows enable
   a_tx_en_gate: assert property ((!tx_serial_out_enable) [*4] |-> !tx_serial_oe)
      else $error("serial line driven while disabled");
   a_tx_pd_quiet: assert property ((!tx_powerdown_n) [*4] |-> !tx_serial_oe && !tx_overrun)
      else $error("serializer active in powerdown");
   a_overrun_sticky: assert property (tx_overrun && tx_powerdown_n && $past(tx_powerdown_n) &&
      $past(tx_powerdown_n, 2) && $past(tx_powerdown_n, 3) |=> tx_overrun)
      else $error("overrun flag lost");
   a_rx_en_gate: assert property ((!rx_parallel_out_enable) [*4] |-> !rx_out_oe)
      else $error("parallel outputs driven while disabled");
   a_rx_oe_lock: assert property (rx_out_oe |-> rx_lock && rx_lock_oe && $past(rx_parallel_out_enable, 2))
      else $error("parallel outputs on without lock");
   a_rx_pd_quiet: assert property ((!rx_powerdown_n) [*4] |-> !rx_lock_oe && !rx_lock)
      else $error("deserializer active in powerdown");
   a_lock_powered: assert property ($rose(rx_lock) |-> rx_lock_oe && $past(rx_lock_oe, 8))
      else $error("lock rose too soon after power up");
   // data moves away from strobe edge
   a_strobe_phase: assert property (lo_moves |-> rx_pixel_clock_out != rx_edge_select)
      else $error("data changed on the strobing phase");
   a_bank_split: assert property ((staggered_output_select and lo_moves) |->
      $stable(rx_parallel_out[23:8]))
      else $error("staggered banks switched together");
   a_bank_unsplit: assert property ((!staggered_output_select and hi_moves) |=>
      $stable(rx_parallel_out[7:0]))
      else $error("low bank lagged without stagger");
endmodule
bind psl_top psl_top_properties chk_u (.clk, .reset, .tx_powerdown_n, .tx_serial_out_enable,
   .tx_serial_oe, .tx_overrun, .rx_edge_select, .rx_parallel_out_enable, .rx_powerdown_n,
   .staggered_output_select, .rx_parallel_out, .rx_pixel_clock_out, .rx_out_oe, .rx_lock, .rx_lock_oe);

// ===== test/psl_host_model.sv
// graphics host and display model at the far side of the link
`timescale 1ns/1ns
`include "psl_cfg.svh"
module psl_host_model (
   input wire logic clk,
   input wire logic run,
   input wire logic zero_data,
   input wire logic [3:0] half_cycles,
   input wire logic tx_edge,
   input wire logic rx_edge,
   output logic pixel_clock,
   output logic [`PSL_WORD_BITS-1:0] pixel_data,
   input wire logic [`PSL_WORD_BITS-1:0] shown_data,
   input wire logic shown_clock,
   input wire logic shown_oe
);
   logic [`PSL_WORD_BITS-1:0] sent_q[$];
   logic [`PSL_WORD_BITS-1:0] seen_q[$];
   logic [3:0] cnt;
   logic [31:0] rnd;
   logic last_clk;
   initial begin
      pixel_clock = 1'b0;
      pixel_data = 24'h0;
      cnt = 4'h0;
      last_clk = 1'b0;
   end
   ////////////////////////////////
   // clock stands still when idle; data moves on the other edge
   always @(negedge clk) begin
      if (run) begin
         cnt <= cnt + 4'h1;
         if (cnt + 4'h1 >= half_cycles) begin
            cnt <= 4'h0;
            pixel_clock <= !pixel_clock;
            rnd = $urandom;
            if (pixel_clock != tx_edge)
               sent_q.push_back(pixel_data);
            else
               pixel_data <= zero_data ? 24'h0 : rnd[23:0];
         end
      end
   end
   ////////////////////////////////
   // display strobes on the chosen recovered edge
   always @(posedge clk) begin
      last_clk <= shown_clock;
      if (shown_oe && shown_clock != last_clk && shown_clock == rx_edge)
         seen_q.push_back(shown_data);
   end
endmodule

// ===== test/psl_top_tb_top.sv
// self-checking bench for the pixel serdes link
`timescale 1ns/1ns
`include "psl_cfg.svh"
module psl_top_tb_top;
   logic clk, reset, tx_pd_n, tx_en, tx_byp, tx_edge, rx_pd_n, rx_en, rx_byp, rx_edge, stag;
   logic run, zero, cut, pclk, oe, ovr, rclk, roe, lock, lock_oe;
   logic [3:0] half;
   logic [1:0] ser, rx_in, noise;
   logic [`PSL_WORD_BITS-1:0] pdata, par_out;
   logic [25:0] win;
   int n_mismatch, samples_checked, cycles, zero_frames;
   psl_top dut_u (.clk(clk), .reset(reset), .tx_pixel_clock(pclk), .tx_pixel_data(pdata),
      .tx_edge_select(tx_edge), .tx_serial_out_enable(tx_en), .tx_powerdown_n(tx_pd_n),
      .tx_scramble_bypass(tx_byp), .tx_serial_out(ser), .tx_serial_oe(oe), .tx_overrun(ovr),
      .rx_serial_in(rx_in), .rx_edge_select(rx_edge), .rx_parallel_out_enable(rx_en),
      .rx_powerdown_n(rx_pd_n), .rx_scramble_bypass(rx_byp), .staggered_output_select(stag),
      .rx_parallel_out(par_out), .rx_pixel_clock_out(rclk), .rx_out_oe(roe), .rx_lock(lock),
      .rx_lock_oe(lock_oe));
   psl_host_model host_u (.clk(clk), .run(run), .zero_data(zero), .half_cycles(half), .tx_edge(tx_edge),
      .rx_edge(rx_edge), .pixel_clock(pclk), .pixel_data(pdata), .shown_data(par_out), .shown_clock(rclk),
      .shown_oe(roe));
   // a released or cut line shows a pattern that changes every cycle
   assign rx_in = (cut || !oe) ? noise : ser;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      noise <= noise + 2'h1;
      win <= {win[23:0], ser};
      if ({win, ser} == {2'h3, 26'h0})
         zero_frames++;
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   ////////////////////////////////
   task automatic report(input bit bad, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (bad) begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
      report(got !== exp, {8'h0, got}, {8'h0, exp});
   endtask
   task automatic check_flag(input logic got, input logic exp);
      report(got !== exp, {31'h0, got}, {31'h0, exp});
   endtask
   task automatic check_count(input int got, input int exp);
      report(got != exp, got, exp);
   endtask
   task automatic wait_lock(input logic want);
      for (int i = 0; i < 600 && lock !== want; i++) @(negedge clk);
      check_flag(lock, want);
   endtask
   task automatic burst(input int n);
      // stop the host first and let words in flight drain before the queues are cleared
      run = 1'b0;
      repeat (100) @(negedge clk);
      host_u.sent_q.delete();
      host_u.seen_q.delete();
      zero_frames = 0;
      run = 1'b1;
      while (host_u.sent_q.size() < n) @(negedge clk);
      run = 1'b0;
      repeat (400) @(negedge clk);
      check_count(host_u.seen_q.size(), host_u.sent_q.size());
      foreach (host_u.sent_q[i])
         if (i < host_u.seen_q.size()) check_word(host_u.seen_q[i], host_u.sent_q[i]);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////
   initial begin
      {reset, tx_pd_n, tx_en, rx_pd_n, rx_en, tx_edge, rx_edge} = 7'h7f;
      {tx_byp, rx_byp, stag, run, zero, cut, noise, win} = '0;
      {n_mismatch, samples_checked, cycles, zero_frames} = '0;
      half = 4'ha;
      void'($urandom(76955));
      repeat (2) @(negedge clk);
      reset = 1'b0;
      run = 1'b1;
      wait_lock(1'b1);
      for (int m = 0; m < 4; m++) begin
         tx_byp = m[0];
         rx_byp = m[0];
         tx_edge = m[1];
         rx_edge = m[0] ^ m[1];
         stag = m[1];
         burst(8 + ($urandom % 8));
      end
      zero = 1'b1;
      burst(6);
      check_count(zero_frames, 6);
      zero = 1'b0;
      cut = 1'b1;
      wait_lock(1'b0);
      cut = 1'b0;
      wait_lock(1'b1);
      rx_en = 1'b0;
      repeat (5) @(negedge clk);
      check_flag(roe, 1'b0);
      check_flag(lock, 1'b1);
      rx_en = 1'b1;
      repeat (5) @(negedge clk);
      check_flag(roe, 1'b1);
      // a released serial line shows noise whose marks never fall a frame apart, so lock must go
      tx_en = 1'b0;
      repeat (5) @(negedge clk);
      check_flag(oe, 1'b0);
      wait_lock(1'b0);
      tx_en = 1'b1;
      wait_lock(1'b1);
      half = 4'h3;
      run = 1'b1;
      for (int i = 0; i < 800 && ovr !== 1'b1; i++) @(negedge clk);
      check_flag(ovr, 1'b1);
      run = 1'b0;
      half = 4'ha;
      tx_pd_n = 1'b0;
      rx_pd_n = 1'b0;
      repeat (5) @(negedge clk);
      check_flag(oe, 1'b0);
      check_flag(ovr, 1'b0);
      check_flag(lock_oe, 1'b0);
      tx_pd_n = 1'b1;
      rx_pd_n = 1'b1;
      run = 1'b1;
      wait_lock(1'b1);
      run = 1'b0;
      burst(10);
      complete_run();
   end
endmodule
